/* hw/rtcal_pkg.sv */
package rtcal_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam int unsigned ADDR_W        = 8;
  localparam logic [5:0]  IDX_MIN       = 6'h01;
  localparam logic [5:0]  IDX_HOUR      = 6'h02;
  localparam logic [5:0]  IDX_WEEK      = 6'h03;
  localparam logic [5:0]  IDX_DAY       = 6'h04;
  localparam logic [5:0]  IDX_MONTH     = 6'h05;
  localparam logic [5:0]  IDX_YEAR      = 6'h06;
  localparam logic [5:0]  IDX_ALARM_SIXTY_MATCH   = 6'h07;
  localparam logic [5:0]  IDX_ALARM_CLOCK_HOUR_MATCH  = 6'h08;
  localparam logic [5:0]  IDX_CTRL      = 6'h10;
  localparam logic [5:0]  IDX_IRQ_STAT  = 6'h11;
  localparam logic [5:0]  IDX_IRQ_CLR   = 6'h12;
  localparam logic [5:0]  IDX_IRQ_EN    = 6'h13;

  // Writable bit masks; bits outside a mask read as zero.
  localparam logic [7:0]  MASK_MIN      = 8'h7f;
  localparam logic [7:0]  MASK_HOUR     = 8'h3f;
  localparam logic [7:0]  MASK_WEEK     = 8'h7f;
  localparam logic [7:0]  MASK_DAY      = 8'h3f;
  localparam logic [7:0]  MASK_MONTH    = 8'h1f;
  localparam logic [7:0]  MASK_YEAR     = 8'hff;
  localparam logic [7:0]  MASK_ALM      = 8'hff;
  localparam logic [7:0]  MASK_CTRL     = 8'h01;
  localparam logic [7:0]  MASK_IRQ      = 8'h03;

  // Counter limits in BCD.
  localparam logic [7:0]  MIN_LO        = 8'h00;
  localparam logic [7:0]  MIN_HI        = 8'h59;
  localparam logic [7:0]  HOUR_LO       = 8'h00;
  localparam logic [7:0]  HOUR_HI       = 8'h23;
  localparam logic [7:0]  DAY_LO        = 8'h01;
  localparam logic [7:0]  MONTH_LO      = 8'h01;
  localparam logic [7:0]  MONTH_HI      = 8'h12;
  localparam logic [7:0]  YEAR_LO       = 8'h00;
  localparam logic [7:0]  YEAR_HI       = 8'h99;

  // Reset values.
  localparam logic [7:0]  RST_WEEK      = 8'h01;
  localparam logic [7:0]  RST_ALM       = 8'h80;
  localparam logic [7:0]  RST_CTRL      = 8'h01;

  // Field positions.
  localparam int unsigned ALM_DIS_BIT   = 7;
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned IRQ_ALARM_BIT = 0;
  localparam int unsigned IRQ_MIN_BIT   = 1;

  // Timing: one minute in seconds at the 25 MHz bus clock.
  localparam longint unsigned CLK_HZ        = 25000000;
  localparam longint unsigned MINUTE_S      = 60;
  localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  function automatic logic [7:0] rtcal_bcd_inc(input logic [7:0] v);
    rtcal_bcd_inc = (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : rtcal_bcd_inc

  function automatic logic [7:0] rtcal_last_day(input logic [7:0] month, input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    if (month == 8'h02) begin
      rtcal_last_day = leap ? 8'h29 : 8'h28;
    end else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11) begin
      rtcal_last_day = 8'h30;
    end else begin
      rtcal_last_day = 8'h31;
    end
  endfunction : rtcal_last_day

endpackage : rtcal_pkg

/* hw/rtcal_bcd_step.sv */
module rtcal_bcd_step (
  input  wire logic [7:0] i_val,   // Current BCD value.
  input  wire logic [7:0] i_lo,    // Value after a wrap.
  input  wire logic [7:0] i_hi,    // Last legal value.
  input  wire logic       i_inc,   // Advance request.
  output logic      [7:0] o_next,  // Value after this step.
  output logic            o_wrap   // Carry into the next counter.
);
  import rtcal_pkg::*;

  // Values at or beyond the top wrap, so an illegal load recovers.
  always_comb begin
    o_wrap = i_inc && (i_val >= i_hi);
    if (!i_inc) begin
      o_next = i_val;
    end else if (o_wrap) begin
      o_next = i_lo;
    end else begin
      o_next = rtcal_bcd_inc(i_val);
    end
  end

endmodule : rtcal_bcd_step

/* hw/rtcal_alarm_cmp.sv */
module rtcal_alarm_cmp (
  input  wire logic [7:0] i_minute,    // Minute counter.
  input  wire logic [7:0] i_hour,      // Hour counter.
  input  wire logic [7:0] i_alarm_sixty_match,   // Minute alarm register.
  input  wire logic [7:0] i_alarm_clock_hour_match,  // Hour alarm register.
  output logic            o_match      // At least one term enabled and all enabled terms match.
);
  import rtcal_pkg::*;

  logic min_en;
  logic hour_en;
  logic min_eq;
  logic hour_eq;

  always_comb begin
    min_en  = !i_alarm_sixty_match[ALM_DIS_BIT];
    hour_en = !i_alarm_clock_hour_match[ALM_DIS_BIT];
    min_eq  = (i_alarm_sixty_match[6:0] == i_minute[6:0]);
    hour_eq = (i_alarm_clock_hour_match[5:0] == i_hour[5:0]);
    o_match = (min_en || hour_en) && (!min_en || min_eq) && (!hour_en || hour_eq);
  end

endmodule : rtcal_alarm_cmp

/* hw/rtcal_regs.sv */
module rtcal_regs #(
  parameter int unsigned CYCLES_PER_MIN = 32'(rtcal_pkg::MINUTE_CYCLES)
) (
  input  wire logic                         i_mclk,          // Bus clock, 25 MHz.
  input  wire logic                         i_rst,           // Synchronous reset, active high.
  input  wire logic                         i_ce,            // Clock enable; low freezes all state.
  input  wire logic [rtcal_pkg::ADDR_W-1:0] i_axi_awaddr,    // Write address.
  input  wire logic                         i_axi_awvalid,   // Write address valid.
  output logic                              o_axi_awready,   // Write address ready.
  input  wire logic [31:0]                  i_axi_wdata,     // Write data.
  input  wire logic [3:0]                   i_axi_wstrb,     // Write byte strobes.
  input  wire logic                         i_axi_wvalid,    // Write data valid.
  output logic                              o_axi_wready,    // Write data ready.
  output logic [1:0]                        o_axi_bresp,     // Write response.
  output logic                              o_axi_bvalid,    // Write response valid.
  input  wire logic                         i_axi_bready,    // Write response ready.
  input  wire logic [rtcal_pkg::ADDR_W-1:0] i_axi_araddr,    // Read address.
  input  wire logic                         i_axi_arvalid,   // Read address valid.
  output logic                              o_axi_arready,   // Read address ready.
  output logic [31:0]                       o_axi_rdata,     // Read data.
  output logic [1:0]                        o_axi_rresp,     // Read response.
  output logic                              o_axi_rvalid,    // Read data valid.
  input  wire logic                         i_axi_rready,    // Read data ready.
  output logic                              o_irq            // Level interrupt.
);
  import rtcal_pkg::*;

  // Bus state.
  logic       aw_full;
  logic [5:0] aw_idx;
  logic       w_full;
  logic [7:0] w_data;
  logic       w_lane;
  logic       next_aw_full;
  logic [5:0] next_aw_idx;
  logic       next_w_full;
  logic [7:0] next_w_data;
  logic       next_w_lane;
  logic       next_awready;
  logic       next_wready;
  logic       next_bvalid;
  logic [1:0] next_bresp;
  logic       next_arready;
  logic       next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic       wr_fire;
  logic       wr_en;
  logic [5:0] rd_idx;

  // Calendar, alarm and interrupt state.
  logic [7:0]  minute_count;
  logic [7:0]  hour_count;
  logic [7:0]  day_of_week_ring;
  logic [7:0]  day_of_month_count;
  logic [7:0]  month_count;
  logic [7:0]  year_count;
  logic [7:0]  alarm_sixty_match;
  logic [7:0]  alarm_clock_hour_match;
  logic [7:0]  ctrl;
  logic [7:0]  irq_status;
  logic [7:0]  irq_enable;
  logic [31:0] prescale;
  logic        match_q;
  logic [7:0]  next_minute_count;
  logic [7:0]  next_hour_count;
  logic [7:0]  next_day_of_week_ring;
  logic [7:0]  next_day_of_month_count;
  logic [7:0]  next_month_count;
  logic [7:0]  next_year_count;
  logic [7:0]  next_alarm_sixty_match;
  logic [7:0]  next_alarm_clock_hour_match;
  logic [7:0]  next_ctrl;
  logic [7:0]  next_irq_status;
  logic [7:0]  next_irq_enable;
  logic [31:0] next_prescale;
  logic        next_irq;

  // Step chain results.
  logic        tick;
  logic [7:0]  step_min;
  logic [7:0]  step_hour;
  logic [7:0]  step_day;
  logic [7:0]  step_month;
  logic [7:0]  step_year;
  logic        wrap_min;
  logic        wrap_hour;
  logic        wrap_day;
  logic        wrap_month;
  logic        wrap_year;
  logic        alarm_match;
  logic [7:0]  irq_events;
  logic [7:0]  irq_clear;

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx >= IDX_MIN && idx <= IDX_ALARM_CLOCK_HOUR_MATCH) ||
                 (idx >= IDX_CTRL && idx <= IDX_IRQ_EN);
  endfunction : idx_mapped

  // Each counter steps only when the one below it wraps, so a tick ripples through in one cycle.
  rtcal_bcd_step u_step_min (
    .i_val  (minute_count),
    .i_lo   (MIN_LO),
    .i_hi   (MIN_HI),
    .i_inc  (tick),
    .o_next (step_min),
    .o_wrap (wrap_min)
  );

  rtcal_bcd_step u_step_hour (
    .i_val  (hour_count),
    .i_lo   (HOUR_LO),
    .i_hi   (HOUR_HI),
    .i_inc  (wrap_min),
    .o_next (step_hour),
    .o_wrap (wrap_hour)
  );

  rtcal_bcd_step u_step_day (
    .i_val  (day_of_month_count),
    .i_lo   (DAY_LO),
    .i_hi   (rtcal_last_day(month_count, year_count)),
    .i_inc  (wrap_hour),
    .o_next (step_day),
    .o_wrap (wrap_day)
  );

  rtcal_bcd_step u_step_month (
    .i_val  (month_count),
    .i_lo   (MONTH_LO),
    .i_hi   (MONTH_HI),
    .i_inc  (wrap_day),
    .o_next (step_month),
    .o_wrap (wrap_month)
  );

  rtcal_bcd_step u_step_year (
    .i_val  (year_count),
    .i_lo   (YEAR_LO),
    .i_hi   (YEAR_HI),
    .i_inc  (wrap_month),
    .o_next (step_year),
    .o_wrap (wrap_year)
  );

  rtcal_alarm_cmp u_alarm_cmp (
    .i_minute   (minute_count),
    .i_hour     (hour_count),
    .i_alarm_sixty_match  (alarm_sixty_match),
    .i_alarm_clock_hour_match (alarm_clock_hour_match),
    .o_match    (alarm_match)
  );

  // AXI4-Lite slave: address and data are taken in either order, then one response.
  always_comb begin
    next_aw_full = aw_full;
    next_aw_idx  = aw_idx;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_lane  = w_lane;
    next_bvalid  = o_axi_bvalid;
    next_bresp   = o_axi_bresp;
    next_rvalid  = o_axi_rvalid;
    next_rdata   = o_axi_rdata;
    next_rresp   = o_axi_rresp;
    rd_idx       = i_axi_araddr[7:2];
    // A write lands only once both halves are held and no response is waiting.
    wr_fire      = aw_full && w_full && !o_axi_bvalid;
    wr_en        = wr_fire && w_lane && idx_mapped(aw_idx);
    if (i_axi_awvalid && o_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_idx  = i_axi_awaddr[7:2];
    end
    if (i_axi_wvalid && o_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = i_axi_wdata[7:0];
      next_w_lane = i_axi_wstrb[0];
    end
    if (o_axi_bvalid && i_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = idx_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (o_axi_rvalid && i_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // Read data is captured at the address handshake and held until the host takes it.
    if (i_axi_arvalid && o_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = 32'h0;
      unique case (rd_idx)
        IDX_MIN:      next_rdata[7:0] = minute_count;
        IDX_HOUR:     next_rdata[7:0] = hour_count;
        IDX_WEEK:     next_rdata[7:0] = day_of_week_ring;
        IDX_DAY:      next_rdata[7:0] = day_of_month_count;
        IDX_MONTH:    next_rdata[7:0] = month_count;
        IDX_YEAR:     next_rdata[7:0] = year_count;
        IDX_ALARM_SIXTY_MATCH:  next_rdata[7:0] = alarm_sixty_match;
        IDX_ALARM_CLOCK_HOUR_MATCH: next_rdata[7:0] = alarm_clock_hour_match;
        IDX_CTRL:     next_rdata[7:0] = ctrl;
        IDX_IRQ_STAT: next_rdata[7:0] = irq_status;
        IDX_IRQ_EN:   next_rdata[7:0] = irq_enable;
        default:      next_rdata[7:0] = 8'h00;
      endcase
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      aw_full       <= 1'b0;
      aw_idx        <= 6'h00;
      w_full        <= 1'b0;
      w_data        <= 8'h00;
      w_lane        <= 1'b0;
      o_axi_awready <= 1'b1;
      o_axi_wready  <= 1'b1;
      o_axi_bvalid  <= 1'b0;
      o_axi_bresp   <= RESP_OKAY;
      o_axi_arready <= 1'b1;
      o_axi_rvalid  <= 1'b0;
      o_axi_rdata   <= 32'h0;
      o_axi_rresp   <= RESP_OKAY;
    end else if (i_ce) begin
      aw_full       <= next_aw_full;
      aw_idx        <= next_aw_idx;
      w_full        <= next_w_full;
      w_data        <= next_w_data;
      w_lane        <= next_w_lane;
      o_axi_awready <= next_awready;
      o_axi_wready  <= next_wready;
      o_axi_bvalid  <= next_bvalid;
      o_axi_bresp   <= next_bresp;
      o_axi_arready <= next_arready;
      o_axi_rvalid  <= next_rvalid;
      o_axi_rdata   <= next_rdata;
      o_axi_rresp   <= next_rresp;
    end
  end

  // Calendar, alarm registers and interrupts; a host write wins over a tick for that register.
  always_comb begin
    tick          = ctrl[CTRL_RUN_BIT] && (prescale >= CYCLES_PER_MIN - 32'd1);
    next_prescale = !ctrl[CTRL_RUN_BIT] ? prescale : (tick ? 32'h0 : prescale + 32'd1);
    next_minute_count       = step_min;
    next_hour_count         = step_hour;
    next_day_of_month_count = step_day;
    next_month_count        = step_month;
    next_year_count         = step_year;
    next_day_of_week_ring   = wrap_hour ? {1'b0, day_of_week_ring[5:0], day_of_week_ring[6]}
                                        : day_of_week_ring;
    next_alarm_sixty_match      = alarm_sixty_match;
    next_alarm_clock_hour_match = alarm_clock_hour_match;
    next_ctrl       = ctrl;
    next_irq_enable = irq_enable;
    irq_clear       = 8'h00;
    if (wr_en) begin
      unique case (aw_idx)
        IDX_MIN:      next_minute_count       = w_data & MASK_MIN;
        IDX_HOUR:     next_hour_count         = w_data & MASK_HOUR;
        IDX_WEEK:     next_day_of_week_ring   = w_data & MASK_WEEK;
        IDX_DAY:      next_day_of_month_count = w_data & MASK_DAY;
        IDX_MONTH:    next_month_count        = w_data & MASK_MONTH;
        IDX_YEAR:     next_year_count         = w_data & MASK_YEAR;
        IDX_ALARM_SIXTY_MATCH:  next_alarm_sixty_match      = w_data & MASK_ALM;
        IDX_ALARM_CLOCK_HOUR_MATCH: next_alarm_clock_hour_match = w_data & MASK_ALM;
        IDX_CTRL:     next_ctrl               = w_data & MASK_CTRL;
        IDX_IRQ_CLR:  irq_clear               = w_data & MASK_IRQ;
        IDX_IRQ_EN:   next_irq_enable         = w_data & MASK_IRQ;
        default:      irq_clear               = 8'h00;
      endcase
    end
    // The alarm event is the rising edge of the match, so a standing match raises it once.
    irq_events                = 8'h00;
    irq_events[IRQ_ALARM_BIT] = alarm_match && !match_q;
    irq_events[IRQ_MIN_BIT]   = tick;
    // A new event in the cycle of its clear keeps the bit set.
    next_irq_status = (irq_status & ~irq_clear) | irq_events;
    next_irq        = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      minute_count           <= MIN_LO;
      hour_count             <= HOUR_LO;
      day_of_week_ring       <= RST_WEEK;
      day_of_month_count     <= DAY_LO;
      month_count            <= MONTH_LO;
      year_count             <= YEAR_LO;
      alarm_sixty_match      <= RST_ALM;
      alarm_clock_hour_match <= RST_ALM;
      ctrl                   <= RST_CTRL;
      irq_status             <= 8'h00;
      irq_enable             <= 8'h00;
      prescale               <= 32'h0;
      match_q                <= 1'b0;
      o_irq                  <= 1'b0;
    end else if (i_ce) begin
      minute_count           <= next_minute_count;
      hour_count             <= next_hour_count;
      day_of_week_ring       <= next_day_of_week_ring;
      day_of_month_count     <= next_day_of_month_count;
      month_count            <= next_month_count;
      year_count             <= next_year_count;
      alarm_sixty_match      <= next_alarm_sixty_match;
      alarm_clock_hour_match <= next_alarm_clock_hour_match;
      ctrl                   <= next_ctrl;
      irq_status             <= next_irq_status;
      irq_enable             <= next_irq_enable;
      prescale               <= next_prescale;
      match_q                <= alarm_match;
      o_irq                  <= next_irq;
    end
  end

endmodule : rtcal_regs

/* verif/rtcal_regs_sva.sv */
module rtcal_regs_sva #(
  parameter int unsigned CYCLES_PER_MIN = 4
) (
  input wire logic                         i_mclk,         // Clock.
  input wire logic                         i_rst,          // Reset.
  input wire logic                         i_ce,           // Clock enable.
  input wire logic [rtcal_pkg::ADDR_W-1:0] i_axi_awaddr,   // Write address.
  input wire logic                         i_axi_awvalid,  // Write address valid.
  input wire logic                         o_axi_awready,  // Write address ready.
  input wire logic                         i_axi_wvalid,   // Write data valid.
  input wire logic                         o_axi_wready,   // Write data ready.
  input wire logic                         o_axi_bvalid,   // Write response valid.
  input wire logic [rtcal_pkg::ADDR_W-1:0] i_axi_araddr,   // Read address.
  input wire logic                         i_axi_arvalid,  // Read address valid.
  input wire logic                         o_axi_arready,  // Read address ready.
  input wire logic [31:0]                  o_axi_rdata,    // Read data.
  input wire logic [1:0]                   o_axi_rresp,    // Read response.
  input wire logic                         o_axi_rvalid,   // Read data valid.
  input wire logic                         i_axi_rready    // Read data ready.
);
  import rtcal_pkg::*;
  logic [5:0] rd_idx;
  logic [5:0] next_rd_idx;
  logic       amin_wr;
  logic       next_amin_wr;
  logic       ahour_wr;
  logic       next_ahour_wr;

  // A written alarm register no longer holds its reset value, so its check stops.
  always_comb begin
    next_rd_idx = (i_axi_arvalid && o_axi_arready) ? i_axi_araddr[7:2] : rd_idx;
    next_amin_wr = amin_wr || (i_axi_awvalid && i_axi_awaddr[7:2] == IDX_ALARM_SIXTY_MATCH);
    next_ahour_wr = ahour_wr || (i_axi_awvalid && i_axi_awaddr[7:2] == IDX_ALARM_CLOCK_HOUR_MATCH);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rd_idx <= 6'h00;
      amin_wr <= 1'b0;
      ahour_wr <= 1'b0;
    end else if (i_ce) begin
      rd_idx <= next_rd_idx;
      amin_wr <= next_amin_wr;
      ahour_wr <= next_ahour_wr;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst || !i_ce);

  property p_min_rsvd;
    o_axi_rvalid && rd_idx == IDX_MIN |-> (o_axi_rdata & 32'hffffff80) == 32'h0;
  endproperty
  a_min_rsvd: assert property (p_min_rsvd) else $error("minute read shows reserved bits");
  property p_hour_rsvd;
    o_axi_rvalid && rd_idx == IDX_HOUR |-> (o_axi_rdata & 32'hffffffc0) == 32'h0;
  endproperty
  a_hour_rsvd: assert property (p_hour_rsvd) else $error("hour read shows reserved bits");
  property p_day_rsvd;
    o_axi_rvalid && rd_idx == IDX_DAY |-> (o_axi_rdata & 32'hffffffc0) == 32'h0;
  endproperty
  a_day_rsvd: assert property (p_day_rsvd) else $error("day read shows reserved bits");
  property p_month_rsvd;
    o_axi_rvalid && rd_idx == IDX_MONTH |-> (o_axi_rdata & 32'hffffffe0) == 32'h0;
  endproperty
  a_month_rsvd: assert property (p_month_rsvd) else $error("month read shows reserved bits");
  property p_amin_rst;
    o_axi_rvalid && rd_idx == IDX_ALARM_SIXTY_MATCH && !amin_wr |-> o_axi_rdata == 32'h80;
  endproperty
  a_amin_rst: assert property (p_amin_rst) else $error("minute alarm reset value wrong");
  property p_ahour_rst;
    o_axi_rvalid && rd_idx == IDX_ALARM_CLOCK_HOUR_MATCH && !ahour_wr |-> o_axi_rdata == 32'h80;
  endproperty
  a_ahour_rst: assert property (p_ahour_rst) else $error("hour alarm reset value wrong");
  property p_unmapped;
    o_axi_rvalid && !(rd_idx inside {[IDX_MIN:IDX_ALARM_CLOCK_HOUR_MATCH], [IDX_CTRL:IDX_IRQ_EN]})
      |-> o_axi_rresp == RESP_SLVERR && o_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_rd_hold;
    o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before taken");
  property p_wr_lat;
    i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready |-> ##2 o_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");

  c_amin_rst: cover property (o_axi_rvalid && rd_idx == IDX_ALARM_SIXTY_MATCH && !amin_wr);
  c_unmapped: cover property (o_axi_rvalid && o_axi_rresp == RESP_SLVERR);
  c_rd_stall: cover property (o_axi_rvalid && !i_axi_rready);
endmodule : rtcal_regs_sva

bind rtcal_regs rtcal_regs_sva #(.CYCLES_PER_MIN(CYCLES_PER_MIN)) u_sva (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_axi_awaddr(i_axi_awaddr),
  .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready), .i_axi_wvalid(i_axi_wvalid),
  .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid), .i_axi_araddr(i_axi_araddr),
  .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready), .o_axi_rdata(o_axi_rdata),
  .o_axi_rresp(o_axi_rresp), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready)
);

/* verif/rtcal_regs_test.sv */
module rtcal_regs_test
  import rtcal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CPM = 200;
  logic        clk, rst, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_q;
  int          n_mismatch = 0;
  int          comparisons = 0;
  logic [5:0]  idx_t [8] = '{IDX_MIN, IDX_HOUR, IDX_WEEK, IDX_DAY, IDX_MONTH, IDX_YEAR, IDX_ALARM_SIXTY_MATCH, IDX_ALARM_CLOCK_HOUR_MATCH};
  logic [7:0]  rst_t [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h80};
  logic [7:0]  msk_t [8] = '{8'h7f, 8'h3f, 8'h7f, 8'h3f, 8'h1f, 8'hff, 8'hff, 8'hff};
  logic [7:0]  roll_t [6] = '{8'h59, 8'h23, 8'h40, 8'h31, 8'h12, 8'h99};
  logic [7:0]  am_t [4] = '{8'h86, 8'h06, 8'h06, 8'h06};
  logic [7:0]  ah_t [4] = '{8'h90, 8'h11, 8'h10, 8'h90};
  logic [7:0]  ex_t [4] = '{8'h02, 8'h02, 8'h03, 8'h03};

  rtcal_regs #(.CYCLES_PER_MIN(CPM)) dut (
    .i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid),
    .o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
    .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Each access starts one edge later so no strobe is assigned twice in one step.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] st = 4'h1);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        resp_q = bresp;
        bready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) chk("write done", 32'h1, 32'h0);
  endtask : wr

  // Ready is raised late on purpose so the slave must hold its answer.
  task automatic rd(input logic [5:0] idx);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'b0;
        n = 99;
      end else if (rvalid) begin
        rready <= 1'b1;
      end
    end
    if (n != 99) chk("read done", 32'h1, 32'h0);
  endtask : rd

  task automatic rc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(nm, {24'h0, exp}, rd_q);
    chk({nm, " resp"}, {30'h0, RESP_OKAY}, {30'h0, resp_q});
  endtask : rc

  // Runs the prescaler until exactly one minute tick has landed.
  task automatic tick();
    int n;
    n = 0;
    wr(IDX_IRQ_CLR, 8'h03);
    wr(IDX_CTRL, 8'h01);
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    wr(IDX_CTRL, 8'h00);
    chk("tick seen", 32'h1, {31'h0, n < 1000});
  endtask : tick

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wr(IDX_CTRL, 8'h00);
    for (int i = 0; i < 8; i++) rc("reset value", idx_t[i], rst_t[i]);
    for (int i = 0; i < 8; i++) begin
      wr(idx_t[i], 8'hff);
      chk("write resp", {30'h0, RESP_OKAY}, {30'h0, resp_q});
      rc("writable bits", idx_t[i], msk_t[i]);
    end
    wr(IDX_YEAR, 8'h42, 4'h0);
    rc("year unstrobed", IDX_YEAR, 8'hff);
    rd(6'h00);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {rd_q[31:2], resp_q});
    wr(6'h3f, 8'h11);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp_q});
    wr(IDX_IRQ_EN, 8'h02);
    for (int i = 0; i < 6; i++) wr(idx_t[i], roll_t[i]);
    wr(IDX_ALARM_SIXTY_MATCH, 8'h80);
    wr(IDX_ALARM_CLOCK_HOUR_MATCH, 8'h80);
    tick();
    for (int i = 0; i < 6; i++) rc("rollover", idx_t[i], rst_t[i]);
    rc("no alarm term", IDX_IRQ_STAT, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_MIN, 8'h05);
      wr(IDX_HOUR, 8'h10);
      wr(IDX_ALARM_SIXTY_MATCH, am_t[i]);
      wr(IDX_ALARM_CLOCK_HOUR_MATCH, ah_t[i]);
      tick();
      rc("alarm status", IDX_IRQ_STAT, ex_t[i]);
    end
    wr(IDX_IRQ_CLR, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_CLR, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // With the prescaler running, a low clock enable must hold off the minute tick.
    wr(IDX_IRQ_EN, 8'h02);
    wr(IDX_CTRL, 8'h01);
    ce <= 1'b0;
    repeat (CPM + 20) @(posedge clk);
    chk("frozen irq", 32'h0, {31'h0, irq});
    ce <= 1'b1;
    wr(IDX_CTRL, 8'h00);
    rc("frozen status", IDX_IRQ_STAT, 8'h00);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule : rtcal_regs_test
